/* dv/srw_host.sv */
// Purpose: Host controller model for the restart pin and write stop pulses
// Assumes: Shares the core clock; drives 1 ns after each rising edge
// Notes:   A forced stop ignores the busy flag to provoke a refusal
`timescale 1ns/1ps
module srw_host #(
    parameter int unsigned WAIT_CYC = 20
) (
    input  wire logic i_mclk,
    input  wire logic i_nv_write_busy,
    output logic      o_wdog_restart,
    output logic      o_nv_write_stop
);
    // Both pins idle low from time zero
    initial begin
        o_wdog_restart  = 1'b0;
        o_nv_write_stop = 1'b0;
    end

    // Pin low for three clocks then high; returns with the pin high
    task automatic kick();
        @(posedge i_mclk);
        #1 o_wdog_restart = 1'b0;
        repeat (3) @(posedge i_mclk);
        #1 o_wdog_restart = 1'b1;
    endtask

    // One-cycle stop; a polite host polls busy for at most the worst write time
    task automatic write_stop(input bit polite);
        int n;
        n = 0;
        while (polite && (i_nv_write_busy !== 1'b0) && (n < WAIT_CYC)) begin
            @(posedge i_mclk);
            #1 n++;
        end
        @(posedge i_mclk);
        #1 o_nv_write_stop = 1'b1;
        @(posedge i_mclk);
        #1 o_nv_write_stop = 1'b0;
    endtask
endmodule

/* dv/tb_supervisor_reset_watchdog_timing.sv */
// Purpose: Self-checking bench for the supervisor timing core
// Assumes: Shortened counts; inputs change 1 ns after the rising edge
// Notes:   Latency windows allow for the two-flop restart synchroniser
`timescale 1ns/1ps
module tb_supervisor_reset_watchdog_timing;
    import srw_pkg::*;
    // Shortened counts for a quick run
    localparam int unsigned RST = 20;
    localparam int unsigned WR  = 10;
    localparam int unsigned WD1 = 40;
    localparam int unsigned WD2 = 60;
    localparam int unsigned WD3 = 90;
    logic i_mclk;                  // Core clock
    logic i_reset_n;               // Power-on reset, active low
    logic [1:0] sel;               // Period selector {hi, lo}
    logic restart;                 // Restart pin from the host
    logic stop;                    // Write stop pulse from the host
    logic sup_reset;               // Reset output
    logic bus_enable;              // Bus may communicate
    logic bus_abort;               // Abort pulse
    logic busy;                    // Write in progress
    logic done;                    // Write finished pulse
    int   failures;                // Mismatch count
    int   checks_done;             // Comparison count

    // Clock of 40 ns period
    initial i_mclk = 1'b0;
    always #20 i_mclk = ~i_mclk;

    srw_top #(.RST_CYC(RST), .WD1_CYC(WD1), .WD2_CYC(WD2), .WD3_CYC(WD3), .WR_CYC(WR)) u_dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wdog_period_sel_hi(sel[1]),
        .i_wdog_period_sel_lo(sel[0]), .i_wdog_restart(restart), .i_nv_write_stop(stop),
        .o_sup_reset(sup_reset), .o_bus_enable(bus_enable), .o_bus_abort(bus_abort),
        .o_nv_write_busy(busy), .o_nv_write_done(done));
    srw_host #(.WAIT_CYC(2 * WR)) u_host (
        .i_mclk(i_mclk), .i_nv_write_busy(busy), .o_wdog_restart(restart), .o_nv_write_stop(stop));

    // Range compare; an unknown never passes
    task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Count edges until the reset output shows the wanted level
    task automatic wait_rst(input logic v, output int n);
        n = 0;
        while ((sup_reset !== v) && (n < 400)) begin
            @(posedge i_mclk);
            #1 n++;
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        if ((failures == 0) && (checks_done > 0)) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Power-up hold length and bus gating
    task automatic test_powerup();
        int n;
        check(sup_reset, 1, 1);
        check(bus_enable, 0, 0);
        #1 i_reset_n = 1'b1;
        wait_rst(1'b0, n);
        check(n, RST + 1, RST + 1);
        check(bus_enable, 1, 1);
    endtask

    // Write timing, a refused stop while busy, then a back-to-back write
    task automatic test_write();
        int n;
        u_host.write_stop(1'b1);
        check(busy, 1, 1);
        u_host.write_stop(1'b0);
        n = 2;
        while ((done !== 1'b1) && (n < 100)) begin
            @(posedge i_mclk);
            #1 n++;
        end
        check(n, WR, WR);
        @(posedge i_mclk);
        #1 check({busy, done}, 0, 0);
        u_host.write_stop(1'b1);
        check(busy, 1, 1);
        u_host.write_stop(1'b1);
        check(busy, 1, 1);
    endtask

    // Count reset assertions over a span of clocks
    task automatic count_resets(input int span, output int hits);
        hits = 0;
        repeat (span) begin
            @(posedge i_mclk);
            #1 hits += int'(sup_reset);
        end
    endtask

    // Selector off: no expiry even past the longest period
    task automatic test_off();
        int hits;
        sel = SEL_OFF;
        u_host.kick();
        count_resets(WD3 + 30, hits);
        check(hits, 0, 0);
    endtask

    // Regular restarts keep the shortest period from expiring
    task automatic test_keepalive();
        int hits;
        sel = SEL_P1;
        repeat (6) begin
            u_host.kick();
            count_resets(26, hits);
            check(hits, 0, 0);
        end
    endtask

    // Each period: expiry time, abort, refused input, hold length
    task automatic test_period(input logic [1:0] s, input int unsigned p);
        int n;
        sel = s;
        repeat (4) @(posedge i_mclk);
        u_host.kick();
        wait_rst(1'b1, n);
        check(n, p + 3, p + 5);
        check({bus_abort, bus_enable}, 2, 2);
        u_host.write_stop(1'b0);
        check(busy, 0, 0);
        wait_rst(1'b0, n);
        check(n + 2, RST, RST + 2);
        check(bus_enable, 1, 1);
    endtask

    // Main sequence
    initial begin
        failures    = 0;
        checks_done = 0;
        i_reset_n   = 1'b0;
        sel         = SEL_OFF;
        repeat (10) @(posedge i_mclk);
        test_powerup();
        test_write();
        test_off();
        test_keepalive();
        test_period(SEL_P1, WD1);
        test_period(SEL_P2, WD2);
        test_period(SEL_P3, WD3);
        test_done();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (5000) @(posedge i_mclk);
        failures++;
        test_done();
    end
endmodule

/* rtl/srw_pkg.sv */
// Purpose: Shared constants and types for the supervisor reset and watchdog timing core
// Assumes: Core clock at 25 MHz
// Notes:   Times keep their printed unit; cycle counts are derived from them
package srw_pkg;
    // Core clock rate in Hz
    localparam int  CLK_HZ             = 25_000_000;
    // Counter width, wide enough for the longest period
    localparam int  TMR_W              = 27;
    // Reset timeout, nominal inside its 100 to 400 ms window
    localparam int  POWERUP_RESET_MS   = 250;
    // Watchdog periods, nominal values
    localparam int  WDOG_P1_MS         = 250;
    localparam int  WDOG_P2_MS         = 650;
    localparam real WDOG_P3_S          = 1.5;
    // Self-timed write, typical and worst case
    localparam int  NV_WRITE_TYP_MS    = 5;
    localparam int  NV_WRITE_MAX_MS    = 10;
    // Derived cycle counts
    localparam int  POWERUP_RESET_CYC  = POWERUP_RESET_MS * (CLK_HZ / 1000);
    localparam int  WDOG_P1_CYC        = WDOG_P1_MS * (CLK_HZ / 1000);
    localparam int  WDOG_P2_CYC        = WDOG_P2_MS * (CLK_HZ / 1000);
    localparam int  WDOG_P3_CYC        = int'(WDOG_P3_S * CLK_HZ);
    localparam int  NV_WRITE_CYC       = NV_WRITE_TYP_MS * (CLK_HZ / 1000);
    localparam int  NV_WRITE_MAX_CYC   = NV_WRITE_MAX_MS * (CLK_HZ / 1000);
    // Period selector codes {hi, lo}
    localparam logic [1:0] SEL_OFF     = 2'h3;
    localparam logic [1:0] SEL_P1      = 2'h2;
    localparam logic [1:0] SEL_P2      = 2'h1;
    localparam logic [1:0] SEL_P3      = 2'h0;
    // Supervisor states
    typedef enum logic [1:0] {
        SRW_HOLD = 2'h0,
        SRW_RUN  = 2'h1
    } srw_state_t;
endpackage

/* rtl/srw_timer.sv */
// Purpose: Loadable down counter that flags the cycle it runs out
// Assumes: Load values of at least one
// Notes:   Count starts from RESET_VALUE after reset release
`timescale 1ns/1ps
module srw_timer #(
    parameter int          W           = 27,
    parameter logic [26:0] RESET_VALUE = 27'h000_0001
) (
    input  wire logic         i_mclk,
    input  wire logic         i_reset_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_load_value,
    input  wire logic         i_run,
    output logic              o_expired,
    output logic [W-1:0]      o_count
);
    logic [W-1:0] cnt_reg;  // Remaining cycles
    logic [W-1:0] cnt_next;
    logic         exp_reg;  // One-cycle run-out flag
    logic         exp_next;

    if (W < 1 || W > 27) begin : g_chk
        $error("srw_timer width out of range");
    end

    // Next count and run-out flag
    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (i_load) begin
            cnt_next = i_load_value;
        end else if (i_run && cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
            exp_next = (cnt_reg == W'(1));
        end
    end

    // Register stage
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= RESET_VALUE[W-1:0];
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign o_expired = exp_reg;
    assign o_count   = cnt_reg;
endmodule

/* rtl/srw_top.sv */
// Purpose: Reset hold, watchdog and write-cycle timing core of a processor supervisor
// Assumes: i_reset_n is the power-on reset; write stop pulses come from a same-clock bus decoder
// Notes:   Select and restart pins are asynchronous and pass two flops first
// Operation
// - Selector: 11 off, 10/01/00 short/mid/long
// - Hold reset output for timeout after power-up
// - Ignore all inputs while reset is asserted; restart and write stop are refused, the selector still sets the first period
// - Finish self-timed write within write-cycle time
// - Reset asserting aborts bus and blocks traffic
`timescale 1ns/1ps
module srw_top
    import srw_pkg::*;
#(
    parameter int unsigned RST_CYC = srw_pkg::POWERUP_RESET_CYC,
    parameter int unsigned WD1_CYC = srw_pkg::WDOG_P1_CYC,
    parameter int unsigned WD2_CYC = srw_pkg::WDOG_P2_CYC,
    parameter int unsigned WD3_CYC = srw_pkg::WDOG_P3_CYC,
    parameter int unsigned WR_CYC  = srw_pkg::NV_WRITE_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_wdog_period_sel_hi,
    input  wire logic i_wdog_period_sel_lo,
    input  wire logic i_wdog_restart,
    input  wire logic i_nv_write_stop,
    output logic      o_sup_reset,
    output logic      o_bus_enable,
    output logic      o_bus_abort,
    output logic      o_nv_write_busy,
    output logic      o_nv_write_done
);
    import srw_pkg::*;

    // Refuse counts the counters cannot hold
    if (RST_CYC < 1 || WD1_CYC < 1 || WD2_CYC < 1 || WD3_CYC < 1 || WR_CYC < 1 ||
        RST_CYC >= 2**TMR_W || WD3_CYC >= 2**TMR_W || WR_CYC > NV_WRITE_MAX_CYC) begin : g_chk
        $error("srw_top count parameter out of range");
    end

    localparam logic [TMR_W-1:0] RST_LD = TMR_W'(RST_CYC);
    localparam logic [TMR_W-1:0] WR_LD  = TMR_W'(WR_CYC);

    // Pin synchronisers
    logic [1:0] sel_s1_reg;     // First stage, read only by second
    logic [1:0] sel_s2_reg;     // Synchronised selector {hi, lo}
    logic       rst_s1_reg;     // First stage of restart pin
    logic       rst_s2_reg;     // Synchronised restart
    logic       rst_d_reg;      // Delayed for edge detect

    // Two-flop synchronisers and restart edge history
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_s1_reg <= SEL_OFF;
            sel_s2_reg <= SEL_OFF;
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
            rst_d_reg  <= 1'b0;
        end else begin
            sel_s1_reg <= {i_wdog_period_sel_hi, i_wdog_period_sel_lo};
            sel_s2_reg <= sel_s1_reg;
            rst_s1_reg <= i_wdog_restart;
            rst_s2_reg <= rst_s1_reg;
            rst_d_reg  <= rst_s2_reg;
        end
    end

    // Supervisor state
    srw_state_t       state_reg;     // Holding reset or running
    srw_state_t       state_next;
    logic             abort_reg;     // Bus abort pulse
    logic             abort_next;
    logic             wd_load;       // Main timer load strobe
    logic [TMR_W-1:0] wd_load_value; // Main timer load value
    logic             wd_run;        // Main timer counts
    logic             wd_expired;    // Main timer ran out
    logic [TMR_W-1:0] wd_count;      // Main timer count
    logic             wd_enabled;    // Watchdog not switched off
    logic [TMR_W-1:0] wd_period;     // Decoded watchdog period
    logic             restart_evt;   // Accepted restart event

    // Period decode from the selector
    always_comb begin
        wd_enabled = 1'b1;
        case (sel_s2_reg)
            SEL_OFF: begin
                wd_enabled = 1'b0;
                wd_period  = TMR_W'(WD1_CYC);
            end
            SEL_P1:  wd_period = TMR_W'(WD1_CYC);
            SEL_P2:  wd_period = TMR_W'(WD2_CYC);
            SEL_P3:  wd_period = TMR_W'(WD3_CYC);
            default: wd_period = TMR_W'(WD3_CYC);
        endcase
    end

    // Restart only counts while running; ignored under reset
    assign restart_evt = (state_reg == SRW_RUN) && rst_s2_reg && !rst_d_reg;

    // Next state, timer control and abort
    always_comb begin
        state_next    = state_reg;
        abort_next    = 1'b0;
        wd_load       = 1'b0;
        wd_load_value = wd_period;
        wd_run        = 1'b1;
        case (state_reg)
            SRW_HOLD: begin
                // Counts the reset timeout, then arms the watchdog
                if (wd_expired) begin
                    state_next = SRW_RUN;
                    wd_load    = 1'b1;
                end
            end
            SRW_RUN: begin
                wd_run = wd_enabled;
                if (wd_enabled && wd_expired) begin
                    // Expiry wins over a restart in the same cycle
                    state_next    = SRW_HOLD;
                    abort_next    = 1'b1;
                    wd_load       = 1'b1;
                    wd_load_value = RST_LD;
                end else if (restart_evt) begin
                    wd_load = 1'b1;
                end
            end
            default: begin
                state_next    = SRW_HOLD;
                wd_load       = 1'b1;
                wd_load_value = RST_LD;
            end
        endcase
    end

    // Supervisor register stage
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= SRW_HOLD;
            abort_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            abort_reg <= abort_next;
        end
    end

    // Reset timeout and watchdog share one counter
    srw_timer #(
        .W           (TMR_W),
        .RESET_VALUE (27'(RST_CYC))
    ) u_wd_timer (
        .i_mclk       (i_mclk),
        .i_reset_n    (i_reset_n),
        .i_load       (wd_load),
        .i_load_value (wd_load_value),
        .i_run        (wd_run),
        .o_expired    (wd_expired),
        .o_count      (wd_count)
    );

    // Write cycle timing
    logic wr_busy_reg;  // Self-timed write in progress
    logic wr_busy_next;
    logic wr_start;     // Accepted write stop
    logic wr_expired;   // Write cycle finished
    logic en_reg;       // Bus enable output
    logic en_next;
    logic sup_rst_reg;  // Reset output, high while holding
    logic sup_rst_next;

    // A stop is only taken while running and idle
    assign wr_start = (state_reg == SRW_RUN) && i_nv_write_stop && !wr_busy_reg;

    // Busy flag and bus enable
    always_comb begin
        wr_busy_next = wr_busy_reg;
        if (wr_start) begin
            wr_busy_next = 1'b1;
        end else if (wr_expired) begin
            wr_busy_next = 1'b0;
        end
        en_next = (state_next == SRW_RUN);
        // Reset output follows the next state so the pin comes from a flop
        sup_rst_next = (state_next == SRW_HOLD);
    end

    // Write and enable register stage
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_busy_reg <= 1'b0;
            en_reg      <= 1'b0;
            sup_rst_reg <= 1'b1;
        end else begin
            wr_busy_reg <= wr_busy_next;
            en_reg      <= en_next;
            sup_rst_reg <= sup_rst_next;
        end
    end

    // Write cycle counter
    srw_timer #(
        .W           (TMR_W),
        .RESET_VALUE (27'h000_0000)
    ) u_wr_timer (
        .i_mclk       (i_mclk),
        .i_reset_n    (i_reset_n),
        .i_load       (wr_start),
        .i_load_value (WR_LD),
        .i_run        (1'b1),
        .o_expired    (wr_expired),
        .o_count      ()
    );

    // Outputs, all from flops
    assign o_sup_reset     = sup_rst_reg;
    assign o_bus_enable    = en_reg;
    assign o_bus_abort     = abort_reg;
    assign o_nv_write_busy = wr_busy_reg;
    assign o_nv_write_done = wr_expired;

    // Checker helper counters
    logic [TMR_W-1:0] hold_cnt_reg; // Cycles spent holding reset
    logic [TMR_W-1:0] busy_cnt_reg; // Cycles spent writing

    // Count cycles in hold and in write
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_cnt_reg <= '0;
            busy_cnt_reg <= '0;
        end else begin
            hold_cnt_reg <= (state_reg == SRW_HOLD) ? hold_cnt_reg + TMR_W'(1) : '0;
            busy_cnt_reg <= wr_busy_reg ? busy_cnt_reg + TMR_W'(1) : '0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_hold_length: assert property ((state_reg == SRW_HOLD && state_next == SRW_RUN)
        |-> hold_cnt_reg == RST_LD)
        else $error("reset hold length wrong");
    a_period_load: assert property ((state_reg == SRW_RUN && wd_load && !wd_expired)
        |=> wd_count == $past(wd_period))
        else $error("watchdog period not loaded");
    a_wdog_off: assert property ((state_reg == SRW_RUN && sel_s2_reg == SEL_OFF)
        |=> !o_sup_reset)
        else $error("disabled watchdog caused reset");
    a_ignore_hold: assert property (o_sup_reset |-> !wr_start && !restart_evt)
        else $error("input taken under reset");
    a_stop_refused: assert property ((o_sup_reset && i_nv_write_stop && !o_nv_write_busy)
        |=> !o_nv_write_busy)
        else $error("write stop taken under reset");
    a_write_length: assert property (o_nv_write_done |-> busy_cnt_reg == WR_LD && o_nv_write_busy)
        else $error("write cycle length wrong");
    a_abort_bus: assert property ($rose(o_sup_reset) |-> o_bus_abort && !o_bus_enable
        ##1 !o_bus_abort)
        else $error("bus not aborted on reset");
    a_wdog_expiry: assert property ((state_reg == SRW_RUN && wd_enabled && wd_expired)
        |=> o_sup_reset && wd_count == RST_LD)
        else $error("watchdog expiry missed");
    a_restart_reload: assert property ((restart_evt && !wd_expired)
        |=> wd_count == $past(wd_period) && !o_sup_reset)
        else $error("restart did not reload");

    c_release: cover property (state_reg == SRW_HOLD && state_next == SRW_RUN);
    c_wdog_bite: cover property (state_reg == SRW_RUN && wd_enabled && wd_expired);
    c_write_done: cover property (o_nv_write_done);
    c_restart: cover property (restart_evt);
endmodule
